// ### design/ptu_chan.sv
// One timer channel: counter, phase decoder and per-register pin logic.
`timescale 1ns/100ps
`default_nettype none
module ptu_chan
    import ptu_pkg::*;
#(
    parameter int NREG      = 4,
    parameter int HAS_PHASE = 0
) (
    input  wire logic                  clk_sys,  // System clock.
    input  wire logic                  rst_n,    // Synchronous reset, active low.
    input  wire ptu_chan_cfg_t         cfg,      // Channel control.
    input  wire logic [2*NREG-1:0]     io_ctl,   // Two mode bits per register.
    input  wire logic [NREG*CNT_W-1:0] cmp_val,  // Compare values, register A low.
    input  wire logic                  cnt_tick, // Selected count enable.
    input  wire logic                  phase_a,  // Synchronised phase A level.
    input  wire logic                  phase_b,  // Synchronised phase B level.
    input  wire logic [NREG-1:0]       pin_in,   // Synchronised pin levels.
    output logic      [NREG-1:0]       pin_out,  // Pin drive level.
    output logic      [NREG-1:0]       pin_oe,   // Pin drive enable.
    output logic      [CNT_W-1:0]      counter,  // Channel counter.
    output logic      [NREG*CNT_W-1:0] capt,     // Captured counts.
    output ptu_events_t                events    // One-cycle event pulses.
);
    // Only two- and four-register channels exist; any other count is refused at elaboration.
    if (NREG != 2 && NREG != 4) begin : g_bad_nreg
        $error("NREG must be 2 or 4");
    end

    logic              prev_a, prev_b, next_prev_a, next_prev_b;
    logic [NREG-1:0]   prev_pin, next_pin_out, next_pin_oe;
    logic [CNT_W-1:0]  next_counter;
    logic [NREG*CNT_W-1:0] next_capt;
    ptu_events_t       next_events;
    logic              up, dn, edge_a, edge_b;
    ptu_io_mode_t      mode;

    always_comb begin
        up = 1'b0;
        dn = 1'b0;
        edge_a = phase_a ^ prev_a;
        edge_b = phase_b ^ prev_b;
        mode = IO_OFF;
        next_prev_a = phase_a;
        next_prev_b = phase_b;
        if (cfg.run) begin
            if (HAS_PHASE != 0 && cfg.phase_mode) begin
                // A leading B counts up, B leading A counts down.
                up = (edge_a && (phase_a != phase_b)) || (edge_b && (phase_a == phase_b));
                dn = (edge_a || edge_b) && !up;
            end else begin
                up = cnt_tick;
            end
        end
        next_counter = up ? counter + 16'h0001 : (dn ? counter - 16'h0001 : counter);
        next_events = '0;
        next_events.ovf = up && counter == CNT_MAX;
        next_events.unf = (HAS_PHASE != 0) && dn && counter == CNT_RST;
        next_capt = capt;
        next_pin_out = pin_out;
        next_pin_oe = '0;
        for (int i = 0; i < NREG; i++) begin
            mode = ptu_io_mode_t'(io_ctl[2*i +: 2]);
            unique case (mode)
                IO_OFF: begin
                end
                IO_TOGGLE: begin
                    next_pin_oe[i] = 1'b1;
                    if ((up || dn) && next_counter == cmp_val[i*CNT_W +: CNT_W]) begin
                        next_pin_out[i] = ~pin_out[i];
                        next_events.gr[i] = 1'b1;
                    end
                end
                IO_CAPTURE: begin
                    if (pin_in[i] && !prev_pin[i]) begin
                        next_capt[i*CNT_W +: CNT_W] = counter;
                        next_events.gr[i] = 1'b1;
                    end
                end
                IO_PWM: begin
                    next_pin_oe[i] = 1'b1;
                    next_pin_out[i] = next_counter < cmp_val[i*CNT_W +: CNT_W];
                    if ((up || dn) && next_counter == cmp_val[i*CNT_W +: CNT_W]) begin
                        next_events.gr[i] = 1'b1;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            prev_a   <= 1'b0;
            prev_b   <= 1'b0;
            prev_pin <= '0;
            counter  <= CNT_RST;
            capt     <= '0;
            pin_out  <= '0;
            pin_oe   <= '0;
            events   <= '0;
        end else begin
            prev_a   <= next_prev_a;
            prev_b   <= next_prev_b;
            prev_pin <= pin_in;
            counter  <= next_counter;
            capt     <= next_capt;
            pin_out  <= next_pin_out;
            pin_oe   <= next_pin_oe;
            events   <= next_events;
        end
    end

    property p_ovf;
        @(posedge clk_sys) disable iff (!rst_n)
        (up && counter == CNT_MAX) |=> (events.ovf && counter == CNT_RST);
    endproperty
    a_ovf: assert property (p_ovf) else $error("overflow not flagged");

    property p_unf;
        @(posedge clk_sys) disable iff (!rst_n)
        (dn && counter == CNT_RST) |=> (events.unf == (HAS_PHASE != 0) && counter == CNT_MAX);
    endproperty
    a_unf: assert property (p_unf) else $error("underflow not flagged");

    property p_capture;
        @(posedge clk_sys) disable iff (!rst_n)
        (io_ctl[1:0] == IO_CAPTURE && pin_in[0] && !prev_pin[0])
            |=> (capt[CNT_W-1:0] == $past(counter) && events.gr[0] && !pin_oe[0]);
    endproperty
    a_capture: assert property (p_capture) else $error("capture missed");

    property p_drive;
        @(posedge clk_sys) disable iff (!rst_n)
        (io_ctl[1:0] == IO_PWM || io_ctl[1:0] == IO_TOGGLE) |=> pin_oe[0];
    endproperty
    a_drive: assert property (p_drive) else $error("output pin not driven");

    sequence s_phase_up;
        cfg.run && cfg.phase_mode && !prev_a && phase_a && !phase_b;
    endsequence
    property p_phase_up;
        @(posedge clk_sys) disable iff (!rst_n)
        ((HAS_PHASE != 0) and s_phase_up) |=> counter == $past(counter) + 16'h0001;
    endproperty
    a_phase_up: assert property (p_phase_up) else $error("phase count wrong");

endmodule // ptu_chan
`default_nettype wire

// ### design/ptu_pkg.sv
// Shared types and constants of the six-channel pulse timer unit.
package ptu_pkg;

    localparam int NUM_CH   = 6;
    localparam int NUM_PIN  = 16;
    localparam int NUM_IRQ  = 26;
    localparam int CNT_W    = 16;
    localparam int PSC_W    = 6;

    // Per channel: general registers, phase mode ability, pin and irq base, control index.
    localparam int CH_NREG     [NUM_CH] = '{4, 2, 2, 4, 2, 2};
    localparam int CH_PHASE    [NUM_CH] = '{0, 1, 1, 0, 1, 1};
    localparam int CH_PIN_BASE [NUM_CH] = '{0, 4, 6, 8, 12, 14};
    localparam int CH_IRQ_BASE [NUM_CH] = '{0, 5, 9, 13, 18, 22};
    localparam int CH_IO_IDX   [NUM_CH] = '{0, 0, 1, 1, 2, 3};
    // Phase source: 0 takes inputs A and B, 1 takes inputs C and D.
    localparam int CH_PH_PAIR  [NUM_CH] = '{0, 0, 1, 0, 1, 0};

    localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
    localparam logic [CNT_W-1:0] CNT_MAX = 16'hFFFF;
    localparam logic [PSC_W-1:0] PSC_RST = 6'h00;

    typedef enum logic [2:0] {
        CLK_DIV1  = 3'h0,
        CLK_DIV4  = 3'h1,
        CLK_DIV16 = 3'h2,
        CLK_DIV64 = 3'h3,
        CLK_EXT_A = 3'h4,
        CLK_EXT_B = 3'h5,
        CLK_EXT_C = 3'h6,
        CLK_EXT_D = 3'h7
    } ptu_clk_sel_t;

    typedef enum logic [1:0] {
        IO_OFF     = 2'h0,
        IO_TOGGLE  = 2'h1,
        IO_CAPTURE = 2'h2,
        IO_PWM     = 2'h3
    } ptu_io_mode_t;

    typedef struct packed {
        logic         run;
        logic         phase_mode;
        ptu_clk_sel_t clk_sel;
        logic [5:0]   irq_en;
    } ptu_chan_cfg_t;

    // Event bits of a channel: general registers A to D, overflow, underflow.
    typedef struct packed {
        logic       unf;
        logic       ovf;
        logic [3:0] gr;
    } ptu_events_t;

endpackage

// ### design/ptu_top.sv
// Pin and interrupt-source level of the six-channel pulse timer unit.
`timescale 1ns/100ps
`default_nettype none
// What this block does
// - Four external clock inputs A to D, selectable as count source by any channel.
// - Channels 1 and 5 phase counting take phase A from A, B from B.
// - Channels 2 and 4 phase counting take phase A from C, B from D.
// - Each general register owns one pin: capture input, compare or PWM output.
// - Channels 0 and 3 have four registers and pins; the others have two.
// - Channels 0 and 3 raise five sources: registers A to D and overflow.
// - Other channels raise four sources: registers A, B, overflow and underflow.
// - Channels 0 and 3 split pin control into high and low; others use one.
module ptu_top
    import ptu_pkg::*;
(
    input  wire logic                 clk_sys,              // 20 MHz system clock.
    input  wire logic                 rst_n,                // Synchronous reset, active low.
    input  wire logic [3:0]           ext_clk_in,           // External clocks A to D.
    input  wire ptu_chan_cfg_t        chan_cfg [NUM_CH],    // Per-channel control.
    input  wire logic [3:0]           pin_io_control_high [2], // Channels 0 and 3, regs A and B.
    input  wire logic [3:0]           pin_io_control_low  [2], // Channels 0 and 3, regs C and D.
    input  wire logic [3:0]           pin_io_control      [4], // Channels 1, 2, 4 and 5.
    input  wire logic [CNT_W-1:0]     cmp_val [NUM_PIN],    // Compare values per pin.
    input  wire logic [NUM_PIN-1:0]   pin_in,               // Pin input levels.
    output logic      [NUM_PIN-1:0]   pin_out,              // Pin output levels.
    output logic      [NUM_PIN-1:0]   pin_oe,               // Pin drive enables.
    output logic      [CNT_W-1:0]     channel_counter [NUM_CH], // Counter values.
    output logic      [CNT_W-1:0]     capt_val [NUM_PIN],   // Captured counts per pin.
    output logic      [NUM_IRQ-1:0]   irq_src               // Enabled source pulses.
);
    logic [3:0]          ext_s1, ext_s2, ext_prev, ext_rise;
    logic [NUM_PIN-1:0]  pin_s1, pin_s2;
    logic [PSC_W-1:0]    psc, next_psc;
    logic [3:0]          tick, next_tick;
    logic [NUM_IRQ-1:0]  next_irq;
    ptu_events_t         ev [NUM_CH];

    // Pins and external clocks are asynchronous; only stage two is used.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            ext_s1   <= '0;
            ext_s2   <= '0;
            ext_prev <= '0;
            pin_s1   <= '0;
            pin_s2   <= '0;
        end else begin
            ext_s1   <= ext_clk_in;
            ext_s2   <= ext_s1;
            ext_prev <= ext_s2;
            pin_s1   <= pin_in;
            pin_s2   <= pin_s1;
        end
    end

    // Rising edge is counted; external edges faster than half of clk_sys are lost.
    always_comb begin
        ext_rise = ext_s2 & ~ext_prev;
    end

    always_comb begin
        next_psc = psc + 6'h01;
        next_tick[0] = 1'b1;
        next_tick[1] = psc[1:0] == 2'h3;
        next_tick[2] = psc[3:0] == 4'hF;
        next_tick[3] = psc == 6'h3F;
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            psc  <= PSC_RST;
            tick <= '0;
        end else begin
            psc  <= next_psc;
            tick <= next_tick;
        end
    end

    for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
        localparam int NR = CH_NREG[c];
        localparam int PB = CH_PIN_BASE[c];
        localparam int PA = CH_PH_PAIR[c];
        logic              sel_tick;
        logic [2*NR-1:0]   io;
        logic [NR*CNT_W-1:0] cmp_flat, capt_flat;

        always_comb begin
            unique case (chan_cfg[c].clk_sel)
                CLK_DIV1:  sel_tick = tick[0];
                CLK_DIV4:  sel_tick = tick[1];
                CLK_DIV16: sel_tick = tick[2];
                CLK_DIV64: sel_tick = tick[3];
                CLK_EXT_A: sel_tick = ext_rise[0];
                CLK_EXT_B: sel_tick = ext_rise[1];
                CLK_EXT_C: sel_tick = ext_rise[2];
                CLK_EXT_D: sel_tick = ext_rise[3];
            endcase
        end

        if (NR == 4) begin : g_io4
            assign io = {pin_io_control_low[CH_IO_IDX[c]],
                         pin_io_control_high[CH_IO_IDX[c]]};
        end else begin : g_io2
            assign io = pin_io_control[CH_IO_IDX[c]];
        end

        for (genvar r = 0; r < NR; r++) begin : g_reg
            assign cmp_flat[r*CNT_W +: CNT_W] = cmp_val[PB+r];
            assign capt_val[PB+r] = capt_flat[r*CNT_W +: CNT_W];
        end

        ptu_chan #(
            .NREG      (NR),
            .HAS_PHASE (CH_PHASE[c])
        ) u_chan (
            .clk_sys  (clk_sys),
            .rst_n    (rst_n),
            .cfg      (chan_cfg[c]),
            .io_ctl   (io),
            .cmp_val  (cmp_flat),
            .cnt_tick (sel_tick),
            .phase_a  (ext_s2[2*PA]),
            .phase_b  (ext_s2[2*PA+1]),
            .pin_in   (pin_s2[PB +: NR]),
            .pin_out  (pin_out[PB +: NR]),
            .pin_oe   (pin_oe[PB +: NR]),
            .counter  (channel_counter[c]),
            .capt     (capt_flat),
            .events   (ev[c])
        );
    end

    // Four-register channels report A to D and overflow; two-register ones report A, B, overflow and underflow.
    always_comb begin
        next_irq = '0;
        for (int c = 0; c < NUM_CH; c++) begin
            if (CH_NREG[c] == 4) begin
                for (int k = 0; k < 4; k++) begin
                    next_irq[CH_IRQ_BASE[c]+k] = ev[c].gr[k] & chan_cfg[c].irq_en[k];
                end
                next_irq[CH_IRQ_BASE[c]+4] = ev[c].ovf & chan_cfg[c].irq_en[4];
            end else begin
                for (int k = 0; k < 2; k++) begin
                    next_irq[CH_IRQ_BASE[c]+k] = ev[c].gr[k] & chan_cfg[c].irq_en[k];
                end
                next_irq[CH_IRQ_BASE[c]+2] = ev[c].ovf & chan_cfg[c].irq_en[4];
                next_irq[CH_IRQ_BASE[c]+3] = ev[c].unf & chan_cfg[c].irq_en[5];
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            irq_src <= '0;
        end else begin
            irq_src <= next_irq;
        end
    end

    property p_irq_ch0_ovf;
        @(posedge clk_sys) disable iff (!rst_n)
        (ev[0].ovf && chan_cfg[0].irq_en[4]) |=> irq_src[4];
    endproperty
    a_irq_ch0_ovf: assert property (p_irq_ch0_ovf) else $error("ch0 overflow lost");

    property p_irq_ch3_d;
        @(posedge clk_sys) disable iff (!rst_n)
        (ev[3].gr[3] && chan_cfg[3].irq_en[3]) |=> irq_src[16];
    endproperty
    a_irq_ch3_d: assert property (p_irq_ch3_d) else $error("ch3 register D lost");

    property p_irq_ch1_unf;
        @(posedge clk_sys) disable iff (!rst_n)
        (ev[1].unf && chan_cfg[1].irq_en[5]) |=> irq_src[8];
    endproperty
    a_irq_ch1_unf: assert property (p_irq_ch1_unf) else $error("ch1 underflow lost");

    property p_div4;
        @(posedge clk_sys) disable iff (!rst_n)
        tick[1] |=> !tick[1] [*3] ##1 tick[1];
    endproperty
    a_div4: assert property (p_div4) else $error("divide by four broken");

    property p_ext_count;
        @(posedge clk_sys) disable iff (!rst_n)
        (chan_cfg[0].run && chan_cfg[0].clk_sel == CLK_EXT_C && ext_rise[2])
            |=> channel_counter[0] == $past(channel_counter[0]) + 16'h0001;
    endproperty
    a_ext_count: assert property (p_ext_count) else $error("external C not counted");

    property p_phase_cd;
        @(posedge clk_sys) disable iff (!rst_n)
        (chan_cfg[2].run && chan_cfg[2].phase_mode && !ext_prev[2] && ext_s2[2] && !ext_s2[3])
            |=> channel_counter[2] == $past(channel_counter[2]) + 16'h0001;
    endproperty
    a_phase_cd: assert property (p_phase_cd) else $error("ch2 phase from C and D wrong");

    property p_io_low;
        @(posedge clk_sys) disable iff (!rst_n)
        (pin_io_control_low[0][1:0] == IO_PWM) |=> pin_oe[2];
    endproperty
    a_io_low: assert property (p_io_low) else $error("low control not steering pin C");

endmodule // ptu_top
`default_nettype wire

// ### verification/ptu_pulse_src.sv
// Behavioural model of the external clock, encoder and pulse sources.
`timescale 1ns/100ps
`default_nettype none
module ptu_pulse_src
    import ptu_pkg::*;
(
    input  wire logic               clk_sys,    // Bench clock, used for pacing only.
    output var  logic [3:0]         ext_clk_in, // External clocks A to D.
    output var  logic [NUM_PIN-1:0] pin_lvl     // Levels offered on the pins.
);
    // Each level stands at least four cycles so the synchronisers never merge two edges.
    int hold = 4;

    initial begin
        ext_clk_in = 4'h0;
        pin_lvl    = '0;
    end

    task automatic wait_hold();
        repeat (hold) @(negedge clk_sys);
    endtask

    task automatic ext_pulse(input int e);
        @(negedge clk_sys);
        ext_clk_in[e] = 1'b1;
        wait_hold();
        ext_clk_in[e] = 1'b0;
        wait_hold();
    endtask

    // Quadrature steps on pair 0 (inputs A, B) or pair 1 (inputs C, D).
    task automatic quad_steps(input int pair, input bit up, input int n);
        for (int i = 0; i < n; i++) begin
            @(negedge clk_sys);
            if ((ext_clk_in[2*pair] == ext_clk_in[2*pair+1]) == up)
                ext_clk_in[2*pair] = ~ext_clk_in[2*pair];
            else
                ext_clk_in[2*pair+1] = ~ext_clk_in[2*pair+1];
            wait_hold();
        end
    endtask

    task automatic pin_set(input int p, input logic lvl);
        @(negedge clk_sys);
        pin_lvl[p] = lvl;
    endtask
endmodule // ptu_pulse_src
`default_nettype wire

// ### verification/test_six_channel_timer_pin_io.sv
// Self-checking bench for the pin and interrupt-source level of the timer unit.
`timescale 1ns/100ps
`default_nettype none
module test_six_channel_timer_pin_io
    import ptu_pkg::*;
();
    logic               clk_sys;
    logic               rst_n;
    logic [3:0]         ext_clk_in;
    ptu_chan_cfg_t      chan_cfg [NUM_CH];
    logic [3:0]         io_hi [2];
    logic [3:0]         io_lo [2];
    logic [3:0]         io_ctl [4];
    logic [CNT_W-1:0]   cmp_val [NUM_PIN];
    logic [NUM_PIN-1:0] pin_wire;
    logic [NUM_PIN-1:0] pin_lvl;
    logic [NUM_PIN-1:0] pin_out;
    logic [NUM_PIN-1:0] pin_oe;
    logic [CNT_W-1:0]   channel_counter [NUM_CH];
    logic [CNT_W-1:0]   capt_val [NUM_PIN];
    logic [NUM_IRQ-1:0] irq_src;
    logic [CNT_W-1:0]   exp_cnt [NUM_CH];
    int                 exp_irq [$];
    int                 err_count = 0;
    int                 compares = 0;
    int                 seed = 49161;

    // A pin the design drives shows the design's level; otherwise the source's.
    assign pin_wire = (pin_oe & pin_out) | (~pin_oe & pin_lvl);

    ptu_top i_ptu_top (.clk_sys(clk_sys), .rst_n(rst_n), .ext_clk_in(ext_clk_in),
        .chan_cfg(chan_cfg), .pin_io_control_high(io_hi), .pin_io_control_low(io_lo),
        .pin_io_control(io_ctl), .cmp_val(cmp_val), .pin_in(pin_wire), .pin_out(pin_out),
        .pin_oe(pin_oe), .channel_counter(channel_counter), .capt_val(capt_val),
        .irq_src(irq_src));

    ptu_pulse_src i_ptu_pulse_src (.clk_sys(clk_sys), .ext_clk_in(ext_clk_in),
        .pin_lvl(pin_lvl));

    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("Error %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    task automatic report_and_stop();
        $display("Checks made %0d, mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // Every source pulse is matched, oldest note first, against the queue of notes.
    always @(negedge clk_sys) begin
        for (int i = 0; i < NUM_IRQ; i++) begin
            if (irq_src[i] === 1'b1) begin
                if (exp_irq.size() == 0)
                    check("unexpected irq source", 32'hFFFF, 32'(i));
                else
                    check("irq source", 32'(exp_irq.pop_front()), 32'(i));
            end
        end
    end

    task automatic do_reset();
        @(negedge clk_sys);
        rst_n = 1'b0;
        check("pending irq notes", 32'h0, 32'(exp_irq.size()));
        exp_irq.delete();
        foreach (chan_cfg[c]) begin
            chan_cfg[c] = '{run: 1'b0, phase_mode: 1'b0, clk_sel: CLK_DIV1, irq_en: 6'h3F};
            exp_cnt[c]  = 16'h0000;
        end
        io_hi  = '{default: 4'h0};
        io_lo  = '{default: 4'h0};
        io_ctl = '{default: 4'h0};
        repeat (10) @(negedge clk_sys);
        rst_n = 1'b1;
        repeat (3) @(negedge clk_sys);
    endtask

    task automatic check_counters();
        foreach (exp_cnt[c]) check("channel counter", 32'(exp_cnt[c]), 32'(channel_counter[c]));
    endtask

    function automatic int chan_of(input int p);
        for (int c = NUM_CH - 1; c >= 0; c--)
            if (p >= CH_PIN_BASE[c]) return c;
        return 0;
    endfunction

    task automatic set_mode(input int p, input ptu_io_mode_t m);
        int c;
        int r;
        c = chan_of(p);
        r = p - CH_PIN_BASE[c];
        if (CH_NREG[c] == 2) io_ctl[CH_IO_IDX[c]][2*r +: 2] = m;
        else if (r < 2) io_hi[CH_IO_IDX[c]][2*r +: 2] = m;
        else io_lo[CH_IO_IDX[c]][2*r-4 +: 2] = m;
    endtask

    initial begin
        int n;
        int c;
        int r;
        rst_n = 1'b0;
        foreach (cmp_val[p]) cmp_val[p] = 16'($random(seed));
        do_reset();
        check_counters();
        // Each channel counts each external input in turn, the others stay frozen.
        for (int ch = 0; ch < NUM_CH; ch++) begin
            for (int e = 0; e < 4; e++) begin
                chan_cfg[ch].run = 1'b1;
                chan_cfg[ch].clk_sel = ptu_clk_sel_t'(3'(4 + e));
                n = 1 + ($unsigned($random(seed)) % 3);
                repeat (n) i_ptu_pulse_src.ext_pulse(e);
                exp_cnt[ch] = exp_cnt[ch] + 16'(n);
                chan_cfg[ch].run = 1'b0;
                check_counters();
            end
        end
        // Phase counting listens to its own pair only and wraps down with underflow.
        for (int ch = 1; ch < NUM_CH; ch++) begin
            if (CH_PHASE[ch] == 0) continue;
            do_reset();
            chan_cfg[ch].run = 1'b1;
            chan_cfg[ch].phase_mode = 1'b1;
            i_ptu_pulse_src.quad_steps(CH_PH_PAIR[ch], 1'b1, 4);
            i_ptu_pulse_src.quad_steps(1 - CH_PH_PAIR[ch], 1'b1, 4);
            exp_cnt[ch] = 16'h0004;
            check_counters();
            exp_irq.push_back(CH_IRQ_BASE[ch] + 3);
            i_ptu_pulse_src.quad_steps(CH_PH_PAIR[ch], 1'b0, 8);
            exp_cnt[ch] = 16'hFFFC;
            repeat (4) @(negedge clk_sys);
            check_counters();
        end
        // Every pin: compare toggle output, then capture input of its own register.
        for (int p = 0; p < NUM_PIN; p++) begin
            c = chan_of(p);
            r = p - CH_PIN_BASE[c];
            do_reset();
            n = 1 + ($unsigned($random(seed)) % 6);
            cmp_val[p] = 16'(n);
            set_mode(p, IO_TOGGLE);
            chan_cfg[c].clk_sel = CLK_EXT_A;
            chan_cfg[c].run = 1'b1;
            exp_irq.push_back(CH_IRQ_BASE[c] + r);
            repeat (n) i_ptu_pulse_src.ext_pulse(0);
            check("pin level", 32'h1, 32'(pin_out[p]));
            check("pin drive", 32'(16'h0001 << p), 32'(pin_oe));
            chan_cfg[c].run = 1'b0;
            set_mode(p, IO_CAPTURE);
            exp_irq.push_back(CH_IRQ_BASE[c] + r);
            repeat (3) @(negedge clk_sys);
            i_ptu_pulse_src.pin_set(p, 1'b1);
            repeat (8) @(negedge clk_sys);
            check("captured count", 32'(n), 32'(capt_val[p]));
            check("pin drive", 32'h0, 32'(pin_oe));
            i_ptu_pulse_src.pin_set(p, 1'b0);
        end
        // Internal rates: a window of k periods of the selected rate counts exactly k.
        do_reset();
        for (int s = 0; s < 4; s++) begin
            n = 1 + ($unsigned($random(seed)) % 4);
            chan_cfg[s].clk_sel = ptu_clk_sel_t'(3'(s));
            chan_cfg[s].run = 1'b1;
            repeat (n << (2 * s)) @(negedge clk_sys);
            chan_cfg[s].run = 1'b0;
            exp_cnt[s] = 16'(n);
            check_counters();
        end
        // Register C of channel 0 as PWM: high below the compare value, low from it on.
        do_reset();
        n = 1 + ($unsigned($random(seed)) % 3);
        cmp_val[2] = 16'(n);
        set_mode(2, IO_PWM);
        chan_cfg[0].clk_sel = CLK_EXT_A;
        chan_cfg[0].run = 1'b1;
        repeat (2) @(negedge clk_sys);
        check("pwm level", 32'h1, 32'(pin_out[2]));
        check("pwm drive", 32'h4, 32'(pin_oe));
        exp_irq.push_back(CH_IRQ_BASE[0] + 2);
        repeat (n) i_ptu_pulse_src.ext_pulse(0);
        check("pwm level", 32'h0, 32'(pin_out[2]));
        chan_cfg[0].run = 1'b0;
        // Channels 0 and 3 wrap together and raise their overflow sources.
        do_reset();
        exp_irq.push_back(CH_IRQ_BASE[0] + 4);
        exp_irq.push_back(CH_IRQ_BASE[3] + 4);
        chan_cfg[0].run = 1'b1;
        chan_cfg[3].run = 1'b1;
        for (int i = 0; i < 70000 && exp_irq.size() > 0; i++) @(negedge clk_sys);
        chan_cfg[0].run = 1'b0;
        chan_cfg[3].run = 1'b0;
        check("pending irq notes", 32'h0, 32'(exp_irq.size()));
        report_and_stop();
    end

    // The run needs about 70000 cycles; anything far beyond that is a hang.
    initial begin
        #(90000 * 50);
        err_count++;
        report_and_stop();
    end
endmodule // test_six_channel_timer_pin_io
`default_nettype wire
